// File: pulse_timer_pkg.sv
// Shared constants for the one-shot pulse timer
package pulse_timer_pkg;
  localparam int          CODE_W          = 4;
  localparam int          CODE_POL_BIT    = 3;
  localparam int          CNT_W           = 22;
  localparam logic [3:0]  CODE_RST        = 4'h0;
  localparam int          START_MASTER    = 500;
  localparam int          FILT_SCALE      = 16;
  localparam int          FILT_OFFSET     = 6;
  localparam int          FILT_W          = 12;
  localparam int          REARM_CYC       = 2;
  localparam logic [2:0]  REARM_CYC_W     = 3'h2;
  localparam logic [31:0] MASTER_DIV_DFLT = 32'h0000007D;
  localparam logic [1:0]  ADDR_CTRL       = 2'h0;
  localparam logic [1:0]  ADDR_STATUS     = 2'h1;
  localparam logic [1:0]  ADDR_CODE       = 2'h2;
  localparam int          CTRL_FALL_BIT   = 0;
  localparam int          CTRL_RETRIG_BIT = 1;
  localparam int          CTRL_MSTOP_BIT  = 2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PULSE = 2'b10,
    ST_REARM = 2'b11
  } state_e;

  // Divide ratio for a setting code; upper half mirrors the lower half
  function automatic logic [CNT_W-1:0] ratio_of(input logic [3:0] code);
    logic [2:0] k;
    k = code[3] ? ~code[2:0] : code[2:0];
    ratio_of = CNT_W'(1) << (3 * k);
  endfunction
endpackage

// File: master_tick.sv
// Master oscillator tick divider
`timescale 1ns/1ns
module master_tick (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Control
  input  wire logic [31:0] div_in,
  input  wire logic        stop_in,
  input  wire logic        restart_in,
  // Tick
  output logic             tick_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } st_s;
  st_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // A restart realigns the period to the accepted trigger edge
    if (restart_in) begin
      s_d.cnt = 32'h0;
    end else if (!stop_in) begin
      if (s_q.cnt + 32'h1 >= div_in) begin
        s_d.cnt = 32'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;
endmodule

// File: code_filter.sv
// Setting code filter: accepts a new code only after it has stayed stable
`timescale 1ns/1ns
module code_filter (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Master tick and raw code
  input  wire logic       tick_in,
  input  wire logic [3:0] raw_in,
  // Accepted code
  output logic [3:0]      code_out
);
  typedef struct packed {
    logic [3:0]  code;
    logic [3:0]  cand;
    logic [11:0] cnt;
  } st_s;
  st_s s_q, s_d;

  function automatic logic [11:0] settle_of(input logic [3:0] a,
                                            input logic [3:0] b);
    logic [3:0] diff;
    diff = (a > b) ? a - b : b - a;
    settle_of = 12'(pulse_timer_pkg::FILT_SCALE *
                    (int'(diff) + pulse_timer_pkg::FILT_OFFSET));
  endfunction

  always_comb begin
    s_d = s_q;
    if (raw_in != s_q.cand) begin
      s_d.cand = raw_in;
      s_d.cnt  = 12'h0;
    end else if (tick_in && s_q.cand != s_q.code) begin
      if (s_q.cnt + 12'h1 >= settle_of(s_q.cand, s_q.code)) begin
        s_d.code = s_q.cand;
        s_d.cnt  = 12'h0;
      end else begin
        s_d.cnt = s_q.cnt + 12'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_out = s_q.code;

  code_jump_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.code != $past(s_q.code) |-> s_q.code == $past(s_q.cand))
    else $error("code changed to a value that was not the stable one");
endmodule

// File: one_shot_pulse_timer.sv
// One-shot pulse timer core with AXI4-Lite control
// Contract
// - A 4-bit setting code picks both the divide ratio and the polarity.
// - Code MSB is the output invert bit: 0 gives high pulses, 1 low pulses.
// - Exactly eight ratios exist: 1, 8, 64, 512, 4096, 2^15, 2^18, 2^21.
// - Codes 0-7 give 8^code; code 15-k gives the same ratio as code k.
// - An accepted edge sets the latch and starts timing; reaching width ends it.
// - Pulse length is the ratio times one master period.
// - An option picks rising or falling trigger edges, never both.
// - Without retrigger, edges are ignored during the pulse and a rearm time.
// - With retrigger, each edge in a pulse restarts timing, without limit.
// - A stopped master oscillator holds an active pulse until it resumes.
// - After reset the output stays low for 500 master periods.
// - After start-up the output goes to its idle level, then edges count.
// - A new code takes effect only after it is stable, with no jumps between.
`timescale 1ns/1ns
module one_shot_pulse_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Trigger and setting
  input  wire logic        trigger_input_in,
  input  wire logic [3:0]  setting_code_in,
  // Pulse output
  output logic             pulse_out,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);
  typedef struct packed {
    pulse_timer_pkg::state_e st;
    logic [21:0]             cnt;
    logic [8:0]              start_cnt;
    logic [2:0]              rearm;
    logic                    trigger_input_prev;
    logic                    pulse;
    logic [2:0]              ctrl;
    logic [31:0]             mdiv;
    logic                    aw_got;
    logic [1:0]              aw_idx;
    logic                    aw_bad;
    logic                    w_got;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    awready;
    logic                    wready;
    logic                    arready;
  } st_s;
  st_s s_q, s_d;

  logic       tick;
  logic       restart;
  logic [3:0] code;
  logic       inv;
  logic       edge_seen;
  logic [21:0] ratio;

  master_tick u_tick (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .div_in   (s_q.mdiv),
    .stop_in  (s_q.ctrl[pulse_timer_pkg::CTRL_MSTOP_BIT]),
    .restart_in (restart),
    .tick_out (tick)
  );

  code_filter u_filter (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tick_in  (tick),
    .raw_in   (setting_code_in),
    .code_out (code)
  );

  assign inv   = code[pulse_timer_pkg::CODE_POL_BIT];
  assign ratio = pulse_timer_pkg::ratio_of(code);
  // Edge sense chosen by the control bit
  assign edge_seen = s_q.ctrl[pulse_timer_pkg::CTRL_FALL_BIT]
                     ? (s_q.trigger_input_prev && !trigger_input_in)
                     : (!s_q.trigger_input_prev && trigger_input_in);
  // Accepted edges restart the master divider so a pulse spans whole periods
  assign restart = edge_seen &&
                   (s_q.st == pulse_timer_pkg::ST_IDLE ||
                    (s_q.st == pulse_timer_pkg::ST_PULSE &&
                     s_q.ctrl[pulse_timer_pkg::CTRL_RETRIG_BIT]));

  always_comb begin
    logic [31:0] rd;
    rd = 32'h0;
    s_d = s_q;
    s_d.trigger_input_prev = trigger_input_in;

    case (s_q.st)
      pulse_timer_pkg::ST_START: begin
        s_d.pulse = 1'b0;
        if (tick) begin
          if (s_q.start_cnt ==
              9'(pulse_timer_pkg::START_MASTER - 1)) begin
            s_d.st = pulse_timer_pkg::ST_IDLE;
            s_d.pulse = inv;
          end else begin
            s_d.start_cnt = s_q.start_cnt + 9'h1;
          end
        end
      end
      pulse_timer_pkg::ST_IDLE: begin
        s_d.pulse = inv;
        if (edge_seen) begin
          s_d.st = pulse_timer_pkg::ST_PULSE;
          s_d.pulse = !inv;
          s_d.cnt = 22'h0;
        end
      end
      pulse_timer_pkg::ST_PULSE: begin
        s_d.pulse = !inv;
        if (edge_seen &&
            s_q.ctrl[pulse_timer_pkg::CTRL_RETRIG_BIT]) begin
          s_d.cnt = 22'h0;
        end else if (tick) begin
          if (s_q.cnt + 22'h1 >= ratio) begin
            s_d.pulse = inv;
            s_d.cnt = 22'h0;
            s_d.rearm = 3'h0;
            s_d.st = s_q.ctrl[pulse_timer_pkg::CTRL_RETRIG_BIT]
                     ? pulse_timer_pkg::ST_IDLE
                     : pulse_timer_pkg::ST_REARM;
          end else begin
            s_d.cnt = s_q.cnt + 22'h1;
          end
        end
      end
      pulse_timer_pkg::ST_REARM: begin
        s_d.pulse = inv;
        if (s_q.rearm + 3'h1 >= pulse_timer_pkg::REARM_CYC_W) begin
          s_d.st = pulse_timer_pkg::ST_IDLE;
        end else begin
          s_d.rearm = s_q.rearm + 3'h1;
        end
      end
      default: begin
        s_d.st = pulse_timer_pkg::ST_START;
      end
    endcase

    // Write channel: address and data in either order
    if (s_axi_awvalid_in && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = s_axi_awaddr_in[3:2];
      s_d.aw_bad = (s_axi_awaddr_in[31:4] != 28'h0) ||
                   (s_axi_awaddr_in[3:2] == 2'h3);
    end
    if (s_axi_wvalid_in && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_in;
      s_d.wstrb = s_axi_wstrb_in;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = pulse_timer_pkg::RESP_OKAY;
      if (s_q.aw_bad) begin
        s_d.bresp = pulse_timer_pkg::RESP_SLVERR;
      end else if (s_q.aw_idx == pulse_timer_pkg::ADDR_CTRL) begin
        if (s_q.wstrb[0]) begin
          s_d.ctrl = s_q.wdata[2:0];
        end
      end else if (s_q.aw_idx == pulse_timer_pkg::ADDR_CODE) begin
        for (int b = 0; b < 4; b++) begin
          if (s_q.wstrb[b]) begin
            s_d.mdiv[8*b +: 8] = s_q.wdata[8*b +: 8];
          end
        end
      end else begin
        s_d.bresp = pulse_timer_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid_in && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = pulse_timer_pkg::RESP_OKAY;
      case (s_axi_araddr_in[3:2])
        pulse_timer_pkg::ADDR_CTRL: rd = {29'h0, s_q.ctrl};
        pulse_timer_pkg::ADDR_STATUS: rd = {24'h0, code, 1'b0,
                                            s_q.pulse, s_q.st};
        pulse_timer_pkg::ADDR_CODE: rd = s_q.mdiv;
        default: s_d.rresp = pulse_timer_pkg::RESP_SLVERR;
      endcase
      if (s_axi_araddr_in[31:4] != 28'h0) begin
        rd = 32'h0;
        s_d.rresp = pulse_timer_pkg::RESP_SLVERR;
      end
      s_d.rdata = rd;
    end else if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    // Ready flags are registered from the next state of the holding flags
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= pulse_timer_pkg::ST_START;
      s_q.mdiv <= pulse_timer_pkg::MASTER_DIV_DFLT;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_out = s_q.pulse;
  assign s_axi_awready_out = s_q.awready;
  assign s_axi_wready_out  = s_q.wready;
  assign s_axi_bvalid_out  = s_q.bvalid;
  assign s_axi_bresp_out   = s_q.bresp;
  assign s_axi_arready_out = s_q.arready;
  assign s_axi_rvalid_out  = s_q.rvalid;
  assign s_axi_rdata_out   = s_q.rdata;
  assign s_axi_rresp_out   = s_q.rresp;

  start_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_START |-> !s_q.pulse)
    else $error("output not low during start-up");
  idle_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_IDLE && $past(s_q.st) ==
    pulse_timer_pkg::ST_IDLE |-> s_q.pulse == $past(inv))
    else $error("idle level does not follow invert bit");
  edge_starts_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_IDLE && edge_seen |=>
    s_q.st == pulse_timer_pkg::ST_PULSE && s_q.cnt == 22'h0
    && s_q.pulse != inv)
    else $error("accepted edge did not start a pulse");
  stop_holds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && !tick && !edge_seen |=>
    s_q.st == pulse_timer_pkg::ST_PULSE && $stable(s_q.cnt))
    else $error("pulse moved without a master tick");
  width_end_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && tick && !edge_seen &&
    s_q.cnt + 22'h1 >= ratio |=> s_q.st != pulse_timer_pkg::ST_PULSE)
    else $error("pulse did not end at the ratio");
  retrig_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && edge_seen &&
    s_q.ctrl[1] |=> s_q.cnt == 22'h0 &&
    s_q.st == pulse_timer_pkg::ST_PULSE)
    else $error("retrigger did not restart timing");
  no_retrig_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && edge_seen && !s_q.ctrl[1]
    && !tick |=> $stable(s_q.cnt))
    else $error("edge disturbed a non-retriggerable pulse");
  rearm_len_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(s_q.st == pulse_timer_pkg::ST_REARM) |->
    (s_q.st == pulse_timer_pkg::ST_REARM)[*2] ##1
    s_q.st == pulse_timer_pkg::ST_IDLE)
    else $error("rearm interval length wrong");
  ratio_map_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ratio == (22'h1 << (3 * (code[3] ? 4'hF - code : code))) &&
    (ratio == 22'h1 || ratio == 22'h8 || ratio == 22'h40 ||
     ratio == 22'h200 || ratio == 22'h1000 || ratio == 22'h8000 ||
     ratio == 22'h40000 || ratio == 22'h200000))
    else $error("divide ratio outside the eight settings");
  edge_sense_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    edge_seen |-> trigger_input_in != s_q.ctrl[0] &&
    s_q.trigger_input_prev == s_q.ctrl[0])
    else $error("edge of the wrong direction accepted");
  start_done_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_START && tick &&
    s_q.start_cnt == 9'(pulse_timer_pkg::START_MASTER - 1) |=>
    s_q.st == pulse_timer_pkg::ST_IDLE && s_q.pulse == $past(inv))
    else $error("start-up did not end at the idle level");
  count_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && tick && !edge_seen &&
    s_q.cnt + 22'h1 < ratio |=> s_q.cnt == $past(s_q.cnt) + 22'h1)
    else $error("pulse count did not advance on a tick");
  rearm_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == pulse_timer_pkg::ST_PULSE && tick && !edge_seen &&
    !s_q.ctrl[1] && s_q.cnt + 22'h1 >= ratio |=>
    s_q.st == pulse_timer_pkg::ST_REARM)
    else $error("non-retriggerable pulse skipped the rearm time");
  timing_restart_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    restart |=> !tick)
    else $error("accepted edge did not restart the master timing");
endmodule

// File: trigger_input_model.sv
// Trigger source model for the one-shot pulse timer
`timescale 1ns/1ns
module trigger_input_model (
  // Clock
  input  wire logic clk_in,
  // Trigger line
  output logic      trigger_input_out
);
  initial trigger_input_out = 1'h0;
  // Each phase is held two clocks so the edge sampler always sees it
  task automatic set_level(input logic v);
    trigger_input_out <= v;
    repeat (2) @(posedge clk_in);
  endtask
  // One full trigger pulse; back-to-back calls space edges by 4 clocks
  task automatic fire();
    set_level(1'h1);
    set_level(1'h0);
  endtask
endmodule

// File: tb_one_shot_pulse_timer.sv
// Self-checking bench for the one-shot pulse timer
`timescale 1ns/1ns
module tb_one_shot_pulse_timer;
  localparam int MDIV = 2;
  logic        clk_in   = 1'h0;
  logic        rst_n_in = 1'h0;
  logic [3:0]  code     = 4'h0;
  logic [31:0] awaddr   = 32'h0;
  logic [31:0] wdata    = 32'h0;
  logic [31:0] araddr   = 32'h0;
  logic        awvalid  = 1'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic        cur_pol  = 1'h0;
  logic        watch    = 1'h0;
  logic        trigger_input, pulse, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [1:0]  bq[$];
  logic [65:0] rq[$];
  int          lq[$];
  int          error_cnt = 0;
  int          compares  = 0;
  int          cyc       = 0;
  int          act_n     = 0;
  logic [3:0]  codes[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                             4'hB, 4'hC, 4'hF, 4'hE, 4'hD};

  one_shot_pulse_timer one_shot_pulse_timer_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .trigger_input_in(trigger_input),
    .setting_code_in(code), .pulse_out(pulse),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready)
  );
  trigger_input_model trigger_input_model_inst (.clk_in(clk_in), .trigger_input_out(trigger_input));

  always #4 clk_in = ~clk_in;

  task automatic final_report();
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    bq.push_back(er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    forever begin
      @(posedge clk_in);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    @(posedge clk_in);
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] er);
    rq.push_back({er, m, e & m});
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    forever begin
      @(posedge clk_in);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    @(posedge clk_in);
  endtask

  task automatic wait_idle();
    repeat (2) @(posedge clk_in);
    for (int i = 0; i < 10000 && pulse !== cur_pol; i++) @(posedge clk_in);
    repeat (3) @(posedge clk_in);
  endtask

  // Old code must still stand halfway through the filter time
  task automatic set_code(input logic [3:0] c);
    int         d;
    logic [3:0] old;
    old = code;
    d = (c > old) ? int'(c - old) : int'(old - c);
    watch <= 1'h0;
    code  <= c;
    repeat (8 * (d + 6) * MDIV) @(posedge clk_in);
    axi_rd(32'h4, {24'h0, old, 4'h0}, 32'hF0, 2'h0);
    repeat (8 * (d + 6) * MDIV + 4 * MDIV + 8) @(posedge clk_in);
    axi_rd(32'h4, {24'h0, c, 1'h0, c[3], 2'h1}, 32'hFF, 2'h0);
    cur_pol <= c[3];
    watch   <= 1'h1;
    @(posedge clk_in);
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      final_report();
    end
  end

  // Results are compared against the oldest pending note
  always @(posedge clk_in) begin
    logic [65:0] r;
    int          e;
    if (bvalid === 1'h1 && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid === 1'h1 && rready) begin
      r = rq.pop_front();
      chk("rresp", 32'(r[65:64]), 32'(rresp));
      chk("rdata", r[31:0], rdata & r[63:32]);
    end
    if (!watch) act_n = 0;
    else if (pulse !== cur_pol) act_n++;
    else if (act_n != 0) begin
      e = (lq.size() > 0) ? lq.pop_front() : -2;
      compares++;
      if (e == -2 || (e >= 0 && (act_n < e || act_n > e + MDIV + 1))) begin
        error_cnt++;
        $display("BAD pulse_len expected %0d seen %0d", e, act_n);
      end
      act_n = 0;
    end
  end

  initial begin
    int          k, s1, s2;
    logic [31:0] r;
    void'($urandom(8734));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(posedge clk_in);
    chk("pulse_rst", 32'h0, 32'(pulse));
    axi_rd(32'h0, 32'h0, 32'h7, 2'h0);
    axi_rd(32'h8, 32'h7D, 32'hFFFFFFFF, 2'h0);
    axi_rd(32'hC, 32'h0, 32'h0, 2'h2);
    axi_wr(32'hC, 32'h1, 2'h2);
    r = $urandom_range(2, 120);
    axi_wr(32'h8, r, 2'h0);
    axi_rd(32'h8, r, 32'hFFFFFFFF, 2'h0);
    axi_wr(32'h8, 32'(MDIV), 2'h0);
    watch <= 1'h1;
    repeat (100) @(posedge clk_in);
    trigger_input_model_inst.fire();
    repeat (20) @(posedge clk_in);
    chk("pulse_start", 32'h0, 32'(pulse));
    repeat (500 * MDIV + 100) @(posedge clk_in);
    foreach (codes[i]) begin
      set_code(codes[i]);
      repeat ($urandom_range(2, 9)) @(posedge clk_in);
      k = codes[i][3] ? 15 - int'(codes[i]) : int'(codes[i]);
      lq.push_back(MDIV << (3 * k));
      trigger_input_model_inst.fire();
      wait_idle();
    end
    lq.push_back(64 * MDIV);
    trigger_input_model_inst.fire();
    repeat (20) @(posedge clk_in);
    trigger_input_model_inst.fire();
    wait_idle();
    axi_wr(32'h0, 32'h2, 2'h0);
    s1 = $urandom_range(6, 60);
    s2 = $urandom_range(6, 60);
    lq.push_back(s1 + s2 + 64 * MDIV);
    trigger_input_model_inst.fire();
    repeat (s1 - 4) @(posedge clk_in);
    trigger_input_model_inst.fire();
    repeat (s2 - 4) @(posedge clk_in);
    trigger_input_model_inst.fire();
    wait_idle();
    axi_wr(32'h0, 32'h1, 2'h0);
    trigger_input_model_inst.set_level(1'h1);
    repeat (10) @(posedge clk_in);
    chk("pulse_rise_off", 32'(cur_pol), 32'(pulse));
    lq.push_back(64 * MDIV);
    trigger_input_model_inst.set_level(1'h0);
    wait_idle();
    axi_wr(32'h0, 32'h0, 2'h0);
    lq.push_back(-1);
    trigger_input_model_inst.fire();
    axi_wr(32'h0, 32'h4, 2'h0);
    repeat (300) @(posedge clk_in);
    chk("pulse_held", 32'(!cur_pol), 32'(pulse));
    axi_wr(32'h0, 32'h0, 2'h0);
    wait_idle();
    chk("pulse_end", 32'(cur_pol), 32'(pulse));
    final_report();
  end
endmodule
